//--- verilog/dmb_cfg.svh
// constants for the drive monitor status bank: offsets, field positions, limits
// assumes one clock domain and a host port that carries 16-bit addresses
// Function
// [R1] host reads monitors in window 7000h..7044h
// [R2] running and set frequency reported unsigned
// [R3] frequency span follows resolution selection
// [R4] bus voltage 0.1 V, up to 3000.0
// [R5] output voltage whole volts, up to 1140
// [R6] current 0.01 A, or 0.1 A large units
// [R7] output power clamped to 0..32767
// [R8] output torque signed, within 200.0 percent
// [R9] input levels packed, virtual inputs from bit10
// [R10] output levels packed in documented bit order
// [R11] pid values are percentage times scale
// [R12] pulse input frequency 0.01 kHz, to 100.00
// [R13] actual output frequency signed, 3000.0/300.00 span
// [R14] remaining time 0.1 min when timing enabled
// [R15] raw analog voltages clamped, third one signed
// [R16] linear speed is pulses per minute over per-metre
// [R17] mirror host value written at 1000h
// [R18] encoder speed signed, span per resolution
// [R19] rotor position 0.1 degree, to 359.9
// [R20] motor temperature whole degrees, 0..200
// [R21] target torque signed, within 200.0 percent
// [R22] resolver position unsigned 0..4095
// [R23] monitors read-only; window writes change nothing
`ifndef DMB_CFG_SVH
`define DMB_CFG_SVH

// ==================================================
// address window
`define DMB_WIN_LO        16'h7000
`define DMB_WIN_HI        16'h7044
`define DMB_COMM_SET_ADDR 16'h1000
`define DMB_NSLOT         28

// ==================================================
// register indices (offset from window base)
`define DMB_IX_RUN_FREQ   7'h00
`define DMB_IX_SET_FREQ   7'h01
`define DMB_IX_BUS_V      7'h02
`define DMB_IX_OUT_V      7'h03
`define DMB_IX_OUT_CUR    7'h04
`define DMB_IX_OUT_PWR    7'h05
`define DMB_IX_OUT_TRQ    7'h06
`define DMB_IX_IN_LVL     7'h07
`define DMB_IX_OUT_LVL    7'h08
`define DMB_IX_LOAD_SPD   7'h0e
`define DMB_IX_PID_SET    7'h0f
`define DMB_IX_PID_FB     7'h10
`define DMB_IX_PULSE_F    7'h12
`define DMB_IX_ACT_FREQ   7'h13
`define DMB_IX_REMAIN     7'h14
`define DMB_IX_AIN1       7'h15
`define DMB_IX_AIN2       7'h16
`define DMB_IX_AIN3       7'h17
`define DMB_IX_LIN_SPD    7'h18
`define DMB_IX_COMM_SET   7'h1b
`define DMB_IX_ENC_SPD    7'h1c
`define DMB_IX_MAIN_F     7'h1d
`define DMB_IX_AUX_F      7'h1e
`define DMB_IX_ROTOR      7'h20
`define DMB_IX_MOTOR_T    7'h21
`define DMB_IX_TGT_TRQ    7'h22
`define DMB_IX_RESOLVER   7'h23
`define DMB_IX_PF_ANGLE   7'h24

// ==================================================
// field positions in the packed level words
`define DMB_VIN_LSB       10
`define DMB_DO_OUT3_BIT   0
`define DMB_DO_RELAY_LSB  1
`define DMB_DO_OUT12_LSB  3
`define DMB_VOUT_LSB      5

// ==================================================
// resolution selection codes and limits
`define DMB_RES_1DEC      2'h1
`define DMB_RES_2DEC      2'h2
`define DMB_LIM_F2DEC     16'h7d00
`define DMB_LIM_F1DEC     16'h7530
`define DMB_LIM_ACT       16'h7530
`define DMB_LIM_BUS       16'h7530
`define DMB_LIM_VOUT      16'h0474
`define DMB_LIM_FULL      16'hffff
`define DMB_CUR_DIV       32'h0000000a
`define DMB_LIM_PWR       16'h7fff
`define DMB_LIM_TRQ       16'h07d0
`define DMB_LIM_PULSE     16'h2710
`define DMB_LIM_TIME      16'hfde8
`define DMB_LIM_AIN       16'h0421
`define DMB_LIM_COMM      16'h2710
`define DMB_LIM_ROTOR     16'h0e0f
`define DMB_LIM_TEMP      16'h00c8
`define DMB_LIM_RESOLVER  16'h0fff

`endif

//--- verilog/dmb_pkg.sv
// types for the drive monitor status bank
// assumes dmb_cfg.svh is on the include path
`include "dmb_cfg.svh"

package dmb_pkg;

	// ==================================================
	// measured quantities from the drive's control logic, same clock
	typedef struct packed {
		logic signed [31:0] run_freq;     // theoretical running freq, signed
		logic signed [31:0] set_freq;     // set frequency, signed
		logic        [31:0] bus_v;        // 0.1 V units
		logic        [31:0] out_v;        // 1 V units
		logic        [31:0] out_cur;      // 0.01 A units
		logic signed [31:0] out_pwr;      // power, signed
		logic signed [31:0] out_trq;      // 0.1 percent
		logic signed [31:0] trq_limit;    // present torque upper limit
		logic        [15:0] load_speed;   // already scaled
		logic        [15:0] pid_set_frac; // 0..ffff = 0..100 percent
		logic        [15:0] pid_fb_frac;  // same scale
		logic        [31:0] pulse_freq;   // 0.01 kHz units
		logic signed [31:0] act_freq;     // actual output freq
		logic        [31:0] remain_time;  // 0.1 min units
		logic        [31:0] ain1_v;       // 0.01 V units
		logic        [31:0] ain2_v;       // 0.01 V units
		logic signed [31:0] ain3_v;       // 0.01 V units, signed
		logic        [31:0] pulses_per_min;
		logic signed [31:0] enc_freq;     // encoder measured freq
		logic        [15:0] main_freq;
		logic        [15:0] aux_freq;
		logic        [31:0] rotor_pos;    // 0.1 degree units
		logic        [31:0] motor_temp;   // degrees C
		logic        [15:0] resolver_pos;
		logic        [15:0] pf_angle;
		logic               running;
		logic               timer_en;
		logic        [4:0]  virtual_input;
		logic        [4:0]  virtual_output;
		logic               out_three;    // output three level
		logic        [1:0]  relay;        // relays one, two
		logic        [1:0]  out_one_two;  // outputs one, two
	} dmb_drive_t;

	// configuration held by the drive's parameter store
	typedef struct packed {
		logic [1:0]  frequency_resolution_select;
		logic        large_unit;           // power rating above 55 kW
		logic [15:0] pid_scale_factor;
		logic [15:0] pulses_per_meter;
	} dmb_cfg_t;

	// host request from the serial link's frame decoder
	typedef struct packed {
		logic        valid;
		logic        write;
		logic [15:0] addr;
		logic [15:0] wdata;
	} dmb_req_t;

	// answer to the frame encoder
	typedef struct packed {
		logic        valid;
		logic        err;
		logic [15:0] rdata;
	} dmb_rsp_t;

endpackage

//--- verilog/dmb_monitor_bank.sv
// drive monitor status bank: read-only monitor registers behind the host port
// assumes requests come from a frame decoder on core_clk, terminal pins are raw
`timescale 1ns/1ps
`include "dmb_cfg.svh"

module dmb_monitor_bank (
	input  wire logic                core_clk,
	input  wire logic                reset,
	input  wire logic                clk_en,
	input  wire dmb_pkg::dmb_drive_t drive,
	input  wire dmb_pkg::dmb_cfg_t   cfg,
	input  wire logic [9:0]          digital_input_terminal,
	input  wire dmb_pkg::dmb_req_t   req,
	output      dmb_pkg::dmb_rsp_t   rsp
);

	// ==================================================
	// slot table: slot number -> register index
	localparam logic [6:0] SLOT_IX [`DMB_NSLOT] = '{
		`DMB_IX_RUN_FREQ, `DMB_IX_SET_FREQ, `DMB_IX_BUS_V,    `DMB_IX_OUT_V,
		`DMB_IX_OUT_CUR,  `DMB_IX_OUT_PWR,  `DMB_IX_OUT_TRQ,  `DMB_IX_IN_LVL,
		`DMB_IX_OUT_LVL,  `DMB_IX_LOAD_SPD, `DMB_IX_PID_SET,  `DMB_IX_PID_FB,
		`DMB_IX_PULSE_F,  `DMB_IX_ACT_FREQ, `DMB_IX_REMAIN,   `DMB_IX_AIN1,
		`DMB_IX_AIN2,     `DMB_IX_AIN3,     `DMB_IX_LIN_SPD,  `DMB_IX_COMM_SET,
		`DMB_IX_ENC_SPD,  `DMB_IX_MAIN_F,   `DMB_IX_AUX_F,    `DMB_IX_ROTOR,
		`DMB_IX_MOTOR_T,  `DMB_IX_TGT_TRQ,  `DMB_IX_RESOLVER, `DMB_IX_PF_ANGLE
	};

	// slot numbers used by the assertions and the packing logic
	localparam int S_RUN = 0;
	localparam int S_SET = 1;
	localparam int S_BUS = 2;
	localparam int S_VOUT = 3;
	localparam int S_PWR = 5;
	localparam int S_TRQ = 6;
	localparam int S_IN = 7;
	localparam int S_OUT = 8;
	localparam int S_COMM = 19;
	localparam int S_RES = 26;

	// ==================================================
	// saturating helpers

	// clamp an unsigned value to an upper limit
	function automatic logic [15:0] sat_u(input logic [31:0] v, input logic [15:0] lim);
		logic [31:0] l;
		l = {16'h0000, lim};
		if (v > l) begin
			sat_u = lim;
		end else begin
			sat_u = v[15:0];
		end
	endfunction

	// clamp a signed value to +/- limit, two's complement result
	function automatic logic [15:0] sat_s(input logic signed [31:0] v,
		input logic [15:0] lim);
		logic signed [31:0] l;
		l = signed'({16'h0000, lim});
		if (v > l) begin
			sat_s = lim;
		end else if (v < -l) begin
			sat_s = 16'(-l);
		end else begin
			sat_s = v[15:0];
		end
	endfunction

	// magnitude of a signed value, direction dropped
	function automatic logic [31:0] mag(input logic signed [31:0] v);
		mag = (v < 0) ? 32'(-v) : 32'(v);
	endfunction

	// ==================================================
	// terminal pin synchroniser (pins are asynchronous to core_clk)
	logic [9:0] din_meta_r;     // first stage, read only by second stage
	logic [9:0] din_meta_nxt;
	logic [9:0] din_sync_r;     // second stage, safe to use
	logic [9:0] din_sync_nxt;

	// next values: shift only while enabled
	always_comb begin
		din_meta_nxt = din_meta_r;
		din_sync_nxt = din_sync_r;
		if (clk_en) begin
			din_meta_nxt = digital_input_terminal;
			din_sync_nxt = din_meta_r;
		end
	end

	// synchroniser flops
	always_ff @(posedge core_clk) begin
		if (reset) begin
			din_meta_r <= 10'h000;
			din_sync_r <= 10'h000;
		end else begin
			din_meta_r <= din_meta_nxt;
			din_sync_r <= din_sync_nxt;
		end
	end

	// ==================================================
	// communication setpoint written by the host
	logic [15:0] comm_set_r;    // last host value, clamped
	logic [15:0] comm_set_nxt;
	logic        comm_wr;       // host write at the setpoint address

	assign comm_wr = clk_en && req.valid && req.write && (req.addr == `DMB_COMM_SET_ADDR);

	// [R17] mirror host setpoint
	always_comb begin
		comm_set_nxt = comm_set_r;
		if (comm_wr) begin
			comm_set_nxt = sat_s(32'(signed'(req.wdata)), `DMB_LIM_COMM);
		end
	end

	// setpoint register
	always_ff @(posedge core_clk) begin
		if (reset) begin
			comm_set_r <= 16'h0000;
		end else begin
			comm_set_r <= comm_set_nxt;
		end
	end

	// ==================================================
	// monitor snapshot: refreshed every enabled cycle from live values
	logic [15:0] mon_r   [`DMB_NSLOT];  // presented values
	logic [15:0] mon_nxt [`DMB_NSLOT];
	logic [15:0] lim_freq;              // span of frequency words
	logic [31:0] cur_scaled;            // current in the unit's resolution
	logic [31:0] pid_set_prod;          // fraction times scale
	logic [31:0] pid_fb_prod;
	logic [31:0] lin_speed;             // metres per minute, unclamped
	logic [15:0] in_word;               // packed input levels
	logic [15:0] out_word;              // packed output levels

	// [R3] span from resolution
	assign lim_freq = (cfg.frequency_resolution_select == `DMB_RES_2DEC) ?
		`DMB_LIM_F2DEC : `DMB_LIM_F1DEC;

	// [R6] current scaling by rating
	assign cur_scaled = cfg.large_unit ? (drive.out_cur / `DMB_CUR_DIV) : drive.out_cur;

	// [R11] percentage times scale, fraction keeps it within 16 bits
	assign pid_set_prod = 32'(drive.pid_set_frac) * 32'(cfg.pid_scale_factor);
	assign pid_fb_prod = 32'(drive.pid_fb_frac) * 32'(cfg.pid_scale_factor);

	// [R16] pulses per minute over pulses per metre
	// a zero divisor reads as zero speed rather than an undefined quotient
	assign lin_speed = (cfg.pulses_per_meter == 16'h0000) ? 32'h00000000 :
		(drive.pulses_per_min / {16'h0000, cfg.pulses_per_meter});

	// [R9] input levels, physical then virtual
	always_comb begin
		in_word = 16'h0000;
		in_word[9:0] = din_sync_r;
		in_word[`DMB_VIN_LSB +: 5] = drive.virtual_input;
	end

	// [R10] output levels in bit order
	always_comb begin
		out_word = 16'h0000;
		out_word[`DMB_DO_OUT3_BIT] = drive.out_three;
		out_word[`DMB_DO_RELAY_LSB +: 2] = drive.relay;
		out_word[`DMB_DO_OUT12_LSB +: 2] = drive.out_one_two;
		out_word[`DMB_VOUT_LSB +: 5] = drive.virtual_output;
	end

	// next snapshot: hold while disabled, else recompute every slot
	always_comb begin
		for (int i = 0; i < `DMB_NSLOT; i++) begin
			mon_nxt[i] = mon_r[i];
		end
		if (clk_en) begin
			// [R2] unsigned magnitudes
			mon_nxt[S_RUN] = sat_u(mag(drive.run_freq), lim_freq);
			mon_nxt[S_SET] = sat_u(mag(drive.set_freq), lim_freq);
			// [R4] bus voltage range
			mon_nxt[S_BUS] = sat_u(drive.bus_v, `DMB_LIM_BUS);
			// [R5] output voltage, zero when stopped
			mon_nxt[S_VOUT] = drive.running ? sat_u(drive.out_v, `DMB_LIM_VOUT) : 16'h0000;
			// [R6] current word
			mon_nxt[4] = sat_u(cur_scaled, `DMB_LIM_FULL);
			// [R7] power, negatives read zero
			mon_nxt[S_PWR] = (!drive.running || drive.out_pwr < 0) ? 16'h0000 :
				sat_u(32'(drive.out_pwr), `DMB_LIM_PWR);
			// [R8] torque while running
			mon_nxt[S_TRQ] = drive.running ? sat_s(drive.out_trq, `DMB_LIM_TRQ) : 16'h0000;
			mon_nxt[S_IN] = in_word;
			mon_nxt[S_OUT] = out_word;
			mon_nxt[9] = drive.load_speed;
			// [R11] pid words
			mon_nxt[10] = pid_set_prod[31:16];
			mon_nxt[11] = pid_fb_prod[31:16];
			// [R12] pulse frequency
			mon_nxt[12] = sat_u(drive.pulse_freq, `DMB_LIM_PULSE);
			// [R13] actual frequency signed
			mon_nxt[13] = sat_s(drive.act_freq, `DMB_LIM_ACT);
			// [R14] remaining time only when timing enabled
			mon_nxt[14] = drive.timer_en ? sat_u(drive.remain_time, `DMB_LIM_TIME) : 16'h0000;
			// [R15] raw analog voltages
			mon_nxt[15] = sat_u(drive.ain1_v, `DMB_LIM_AIN);
			mon_nxt[16] = sat_u(drive.ain2_v, `DMB_LIM_AIN);
			mon_nxt[17] = sat_s(drive.ain3_v, `DMB_LIM_AIN);
			// [R16] linear speed word
			mon_nxt[18] = sat_u(lin_speed, `DMB_LIM_FULL);
			// [R17] setpoint mirror
			mon_nxt[S_COMM] = comm_set_r;
			// [R18] encoder speed signed
			mon_nxt[20] = sat_s(drive.enc_freq, lim_freq);
			mon_nxt[21] = drive.main_freq;
			mon_nxt[22] = drive.aux_freq;
			// [R19] rotor position
			mon_nxt[23] = sat_u(drive.rotor_pos, `DMB_LIM_ROTOR);
			// [R20] motor temperature
			mon_nxt[24] = sat_u(drive.motor_temp, `DMB_LIM_TEMP);
			// [R21] torque limit as target
			mon_nxt[25] = sat_s(drive.trq_limit, `DMB_LIM_TRQ);
			// [R22] resolver count
			mon_nxt[S_RES] = drive.resolver_pos & `DMB_LIM_RESOLVER;
			mon_nxt[27] = drive.pf_angle;
		end
	end

	// snapshot flops
	always_ff @(posedge core_clk) begin
		if (reset) begin
			for (int i = 0; i < `DMB_NSLOT; i++) begin
				mon_r[i] <= 16'h0000;
			end
		end else begin
			for (int i = 0; i < `DMB_NSLOT; i++) begin
				mon_r[i] <= mon_nxt[i];
			end
		end
	end

	// ==================================================
	// host port: one answer, one cycle after each taken request
	logic        in_win;        // address falls in the monitor window
	logic [6:0]  win_ix;        // index within the window
	logic [15:0] rd_val;        // decoded read value
	logic        rsp_valid_r;
	logic        rsp_valid_nxt;
	logic        rsp_err_r;
	logic        rsp_err_nxt;
	logic [15:0] rsp_data_r;
	logic [15:0] rsp_data_nxt;

	assign in_win = (req.addr >= `DMB_WIN_LO) && (req.addr <= `DMB_WIN_HI);
	assign win_ix = 7'(req.addr - `DMB_WIN_LO);

	// [R1] window decode; unassigned indices read zero
	always_comb begin
		rd_val = 16'h0000;
		for (int i = 0; i < `DMB_NSLOT; i++) begin
			if (SLOT_IX[i] == win_ix) begin
				rd_val = mon_r[i];
			end
		end
	end

	// answer next values; the answer is a pulse, data holds until the next
	always_comb begin
		rsp_valid_nxt = 1'b0;
		rsp_err_nxt = rsp_err_r;
		rsp_data_nxt = rsp_data_r;
		if (!clk_en) begin
			rsp_valid_nxt = rsp_valid_r;
		end else if (req.valid) begin
			rsp_valid_nxt = 1'b1;
			rsp_err_nxt = 1'b0;
			rsp_data_nxt = 16'h0000;
			if (req.addr == `DMB_COMM_SET_ADDR) begin
				rsp_data_nxt = req.write ? 16'h0000 : comm_set_r;
			end else if (in_win) begin
				// [R23] window writes are acknowledged and dropped
				rsp_data_nxt = req.write ? 16'h0000 : rd_val;
			end else begin
				rsp_err_nxt = 1'b1;
			end
		end
	end

	// answer flops
	always_ff @(posedge core_clk) begin
		if (reset) begin
			rsp_valid_r <= 1'b0;
			rsp_err_r <= 1'b0;
			rsp_data_r <= 16'h0000;
		end else begin
			rsp_valid_r <= rsp_valid_nxt;
			rsp_err_r <= rsp_err_nxt;
			rsp_data_r <= rsp_data_nxt;
		end
	end

	assign rsp.valid = rsp_valid_r;
	assign rsp.err = rsp_err_r;
	assign rsp.rdata = rsp_data_r;

	// ==================================================
	// assertions
	default clocking dmb_cb @(posedge core_clk); endclocking
	default disable iff (reset);

	// three enabled edges carry a pin level into the snapshot
	sequence s_pins_settle;
		clk_en [*3];
	endsequence

	// host write taken at the setpoint address
	sequence s_comm_write;
		clk_en && req.valid && req.write && req.addr == `DMB_COMM_SET_ADDR;
	endsequence

	// request taken outside the window and the setpoint address
	sequence s_refused_req;
		clk_en && req.valid && !in_win && req.addr != `DMB_COMM_SET_ADDR;
	endsequence

	// [R1] read gets answer
	a_window_read: assert property (clk_en && req.valid && !req.write && in_win // [R1]
		|=> rsp.valid && !rsp.err) else $error("window read not answered");
	// [R1] answer lasts one cycle
	a_answer_pulse: assert property (clk_en && rsp.valid && !req.valid // [R1]
		|=> !rsp.valid) else $error("answer pulse too long");
	// [R1] refused address flagged
	a_refused_err: assert property (s_refused_req // [R1]
		|=> rsp.valid && rsp.err && rsp.rdata == 16'h0000)
		else $error("refused access not flagged");
	// [R1] answer frozen when disabled
	a_answer_frozen: assert property (!clk_en // [R1]
		|=> $stable(rsp.valid) && $stable(rsp.rdata)) else $error("answer moved while frozen");
	// [R2] magnitudes within span
	a_freq_unsigned: assert property (mon_r[S_RUN] <= `DMB_LIM_F2DEC // [R2]
		&& mon_r[S_SET] <= `DMB_LIM_F2DEC) else $error("frequency word too big");
	// [R3] one-decimal span
	a_freq_span: assert property (clk_en // [R3]
		&& cfg.frequency_resolution_select == `DMB_RES_1DEC
		|=> mon_r[S_RUN] <= `DMB_LIM_F1DEC) else $error("one-decimal span exceeded");
	// [R4] bus voltage limit
	a_bus_range: assert property (mon_r[S_BUS] <= `DMB_LIM_BUS) // [R4]
		else $error("bus voltage out of range");
	// [R5] stopped reads zero
	a_vout_stopped: assert property (clk_en && !drive.running // [R5]
		|=> mon_r[S_VOUT] == 16'h0000) else $error("voltage shown while stopped");
	// [R7] power below 32768
	a_power_range: assert property (!mon_r[S_PWR][15]) // [R7]
		else $error("power above 32767");
	// [R8] torque within limit
	a_torque_range: assert property ($signed(mon_r[S_TRQ]) <= $signed(`DMB_LIM_TRQ) // [R8]
		&& $signed(mon_r[S_TRQ]) >= -$signed(`DMB_LIM_TRQ))
		else $error("torque out of range");
	// [R9] pins reach input word
	a_input_pack: assert property (s_pins_settle // [R9]
		|=> mon_r[S_IN][9:0] == $past(digital_input_terminal, 3))
		else $error("input level word wrong");
	// [R10] output word layout
	a_output_pack: assert property (clk_en |=> mon_r[S_OUT][10 +: 6] == 6'h00 // [R10]
		&& mon_r[S_OUT][`DMB_DO_OUT3_BIT] == $past(drive.out_three))
		else $error("output level word wrong");
	// [R14] timer off reads zero
	a_time_disabled: assert property (clk_en && !drive.timer_en // [R14]
		|=> mon_r[14] == 16'h0000) else $error("remaining time shown while timing off");
	// [R17] setpoint reaches monitor
	a_comm_mirror: assert property (s_comm_write ##1 clk_en // [R17]
		|=> mon_r[S_COMM] == $past(comm_set_r)) else $error("setpoint not mirrored");
	// [R19] rotor within range
	a_rotor_range: assert property (mon_r[23] <= `DMB_LIM_ROTOR) // [R19]
		else $error("rotor position out of range");
	// [R20] temperature within range
	a_temp_range: assert property (mon_r[24] <= `DMB_LIM_TEMP) // [R20]
		else $error("motor temperature out of range");
	// [R22] resolver within 4095
	a_resolver_range: assert property (mon_r[S_RES][15:12] == 4'h0) // [R22]
		else $error("resolver above 4095");
	// [R23] window write dropped
	a_write_dropped: assert property (clk_en && req.valid && req.write && in_win // [R23]
		|=> rsp.valid && rsp.rdata == 16'h0000 && !rsp.err)
		else $error("window write misanswered");

endmodule // dmb_monitor_bank

//--- tb/dmb_host_model.sv
// host computer model: single read and write requests to the monitor bank
// assumes callers enter its task just after a falling edge of core_clk
`timescale 1ns/1ps

module dmb_host_model (
	input  wire logic              core_clk,
	output      dmb_pkg::dmb_req_t req,
	input  wire dmb_pkg::dmb_rsp_t rsp
);
	// ==================================================
	// request side
	// idle until the first transfer
	initial req = '0;

	// one window access
	// waits a fresh falling edge first so valid is never set twice in one step
	task automatic xfer(input logic wr, input logic [15:0] a, input logic [15:0] d,
		output logic [15:0] q, output logic e);
		int n;
		@(negedge core_clk);
		req.valid = 1'b1;
		req.write = wr;
		req.addr = a;
		req.wdata = d;
		@(negedge core_clk);
		// released fields flip so a stale address is never taken as live
		req.valid = 1'b0;
		req.addr = ~a;
		req.wdata = ~d;
		n = 0;
		// bounded wait for the answer pulse
		while (rsp.valid !== 1'b1 && n < 4) begin
			@(negedge core_clk);
			n++;
		end
		q = rsp.rdata;
		// a missing answer shows as an unknown flag and fails the compare
		e = (n < 4) ? rsp.err : 1'bx;
	endtask
endmodule // dmb_host_model

//--- tb/tb_top.sv
// self-checking bench for the drive monitor status bank
// assumes the design package and the host model are compiled first
`timescale 1ns/1ps

module tb_top;
	// ==================================================
	// stimulus and result holders
	logic                core_clk    = 1'b0;  // 250 MHz
	logic                reset       = 1'b1;  // synchronous, active high
	logic                clk_en      = 1'b1;  // dropped once to freeze the block
	dmb_pkg::dmb_drive_t drv         = '0;    // measured values
	dmb_pkg::dmb_cfg_t   cfg_v       = '0;    // parameter store
	logic [9:0]          dit         = 10'h000;
	dmb_pkg::dmb_req_t   req;
	dmb_pkg::dmb_rsp_t   rsp;
	int                  n_mismatch  = 0;
	int                  comparisons = 0;
	int                  cyc         = 0;
	logic [15:0]         q;
	logic                e;

	always #2 core_clk = ~core_clk;

	dmb_monitor_bank u_dmb_monitor_bank (
		.core_clk(core_clk),
		.reset(reset),
		.clk_en(clk_en),
		.drive(drv),
		.cfg(cfg_v),
		.digital_input_terminal(dit),
		.req(req),
		.rsp(rsp)
	);

	dmb_host_model u_dmb_host_model (
		.core_clk(core_clk),
		.req(req),
		.rsp(rsp)
	);

	// ==================================================
	// compare and access helpers
	task automatic cmp16(input string nm, input logic [15:0] exp, input logic [15:0] got);
		comparisons++;
		if (got !== exp) begin
			n_mismatch++;
			$display("[FAIL] %s expected %h seen %h", nm, exp, got);
		end
	endtask

	task automatic cmp1(input string nm, input logic exp, input logic got);
		comparisons++;
		if (got !== exp) begin
			n_mismatch++;
			$display("[FAIL] %s expected %b seen %b", nm, exp, got);
		end
	endtask

	// read a word that must answer without error
	task automatic rd(input logic [15:0] a, input logic [15:0] exp);
		u_dmb_host_model.xfer(1'b0, a, 16'h0000, q, e);
		cmp1($sformatf("err at %h", a), 1'b0, e);
		cmp16($sformatf("word at %h", a), exp, q);
	endtask

	// write or refused read: data answer is always zero
	task automatic acc(input logic wr, input logic [15:0] a, input logic [15:0] d,
		input logic exp_e);
		u_dmb_host_model.xfer(wr, a, d, q, e);
		cmp1($sformatf("err at %h", a), exp_e, e);
		cmp16($sformatf("answer at %h", a), 16'h0000, q);
	endtask

	// snapshot plus pin synchroniser need a few edges
	task automatic settle;
		repeat (4) @(negedge core_clk);
	endtask

	// ==================================================
	// scenarios
	task automatic t_freq;
		drv.run_freq = -32'sd12345;
		drv.set_freq = 32'sd40000;
		drv.act_freq = -32'sd31000;
		drv.enc_freq = -32'sd40000;
		cfg_v.frequency_resolution_select = 2'h2;
		settle();
		rd(16'h7000, 16'h3039);
		rd(16'h7001, 16'h7d00);
		rd(16'h7013, 16'h8ad0);
		rd(16'h701c, 16'h8300);
		cfg_v.frequency_resolution_select = 2'h1;
		settle();
		rd(16'h7001, 16'h7530);
		rd(16'h7013, 16'h8ad0);
	endtask

	task automatic t_power;
		drv.bus_v = 32'd30001;
		drv.out_v = 32'd2000;
		drv.out_cur = 32'd12345;
		drv.out_pwr = -32'sd5;
		drv.out_trq = -32'sd2500;
		drv.trq_limit = 32'sd2500;
		drv.running = 1'b1;
		settle();
		rd(16'h7002, 16'h7530);
		rd(16'h7003, 16'h0474);
		rd(16'h7004, 16'h3039);
		rd(16'h7005, 16'h0000);
		rd(16'h7006, 16'hf830);
		rd(16'h7022, 16'h07d0);
		drv.out_pwr = 32'sd40000;
		cfg_v.large_unit = 1'b1;
		settle();
		rd(16'h7005, 16'h7fff);
		rd(16'h7004, 16'h04d2);
		drv.running = 1'b0;
		settle();
		rd(16'h7003, 16'h0000);
	endtask

	task automatic t_levels;
		dit = 10'h2a5;
		drv.virtual_input = 5'h13;
		drv.out_three = 1'b1;
		drv.relay = 2'h2;
		drv.out_one_two = 2'h1;
		drv.virtual_output = 5'h15;
		settle();
		rd(16'h7007, 16'h4ea5);
		rd(16'h7008, 16'h02ad);
	endtask

	task automatic t_misc;
		drv.pid_set_frac = 16'h8000;
		drv.pid_fb_frac = 16'h4000;
		drv.ain2_v = 32'd500;
		drv.load_speed = 16'h1234;
		cfg_v.pid_scale_factor = 16'h03e8;
		drv.pulse_freq = 32'd10001;
		drv.remain_time = 32'd70000;
		drv.timer_en = 1'b1;
		drv.ain1_v = 32'd2000;
		drv.ain3_v = -32'sd2000;
		drv.pulses_per_min = 32'd6000;
		cfg_v.pulses_per_meter = 16'h001e;
		drv.rotor_pos = 32'd4000;
		drv.motor_temp = 32'd300;
		drv.resolver_pos = 16'h1234;
		settle();
		rd(16'h700f, 16'h01f4);
		rd(16'h7012, 16'h2710);
		rd(16'h7014, 16'hfde8);
		rd(16'h7015, 16'h0421);
		rd(16'h7017, 16'hfbdf);
		rd(16'h7018, 16'h00c8);
		rd(16'h7020, 16'h0e0f);
		rd(16'h7021, 16'h00c8);
		rd(16'h7023, 16'h0234);
		rd(16'h7010, 16'h00fa);
		rd(16'h7016, 16'h01f4);
		rd(16'h700e, 16'h1234);
		drv.timer_en = 1'b0;
		cfg_v.pulses_per_meter = 16'h0000;
		settle();
		rd(16'h7014, 16'h0000);
		rd(16'h7018, 16'h0000);
	endtask

	task automatic t_setpoint;
		acc(1'b1, 16'h1000, 16'h03e8, 1'b0);
		rd(16'h701b, 16'h03e8);
		acc(1'b1, 16'h1000, 16'hb1e0, 1'b0);
		rd(16'h701b, 16'hd8f0);
		rd(16'h1000, 16'hd8f0);
	endtask

	// writes inside the window and accesses outside it
	task automatic t_access;
		acc(1'b1, 16'h7002, 16'hffff, 1'b0);
		rd(16'h7002, 16'h7530);
		acc(1'b1, 16'h701b, 16'h1111, 1'b0);
		rd(16'h701b, 16'hd8f0);
		rd(16'h7009, 16'h0000);
		acc(1'b0, 16'h7045, 16'h0000, 1'b1);
		acc(1'b0, 16'h6fff, 16'h0000, 1'b1);
		acc(1'b1, 16'h7045, 16'h0001, 1'b1);
	endtask

	// enable low freezes the answer; it resumes on the next enabled edge
	task automatic t_hold;
		rd(16'h7002, 16'h7530);
		clk_en = 1'b0;
		drv.bus_v = 32'd100;
		settle();
		cmp1("answer held", 1'b1, rsp.valid);
		cmp16("data held", 16'h7530, rsp.rdata);
		clk_en = 1'b1;
		@(negedge core_clk);
		cmp1("answer pulse ended", 1'b0, rsp.valid);
		rd(16'h7002, 16'h0064);
	endtask

	// ==================================================
	// verdict and run control
	task automatic summarize;
		$display("comparisons %0d mismatches %0d", comparisons, n_mismatch);
		if (n_mismatch == 0 && comparisons > 0) begin
			$display("No errors found");
		end else begin
			$display("Errors were found");
		end
		$finish;
	endtask

	// hang guard, well above the roughly 135 cycles the run needs
	always @(posedge core_clk) begin
		cyc++;
		if (cyc == 3000) begin
			n_mismatch++;
			summarize();
		end
	end

	// main sequence: reset two cycles, then each scenario in turn
	initial begin
		repeat (2) @(negedge core_clk);
		reset = 1'b0;
		rd(16'h7002, 16'h0000);
		t_freq();
		t_power();
		t_levels();
		t_misc();
		t_setpoint();
		t_access();
		t_hold();
		summarize();
	end
endmodule // tb_top
